// ==== verilog/sfp_pkg.sv ====
// Shared types and constants for the serial flash pin front end.
// Assumes a single system clock; all pin traffic is sampled by it.
package sfp_pkg;

	// ****************************************
	// Lane roles
	// ****************************************
	typedef enum logic [1:0] {
		SFP_LANES_SINGLE = 2'h0,
		SFP_LANES_DUAL   = 2'h1,
		SFP_LANES_QUAD   = 2'h3
	} sfp_lane_mode_t;

	// Interface state, Gray along unarmed, idle, selected, paused
	typedef enum logic [1:0] {
		SFP_ST_UNARMED  = 2'h0,
		SFP_ST_IDLE     = 2'h1,
		SFP_ST_SELECTED = 2'h3,
		SFP_ST_PAUSED   = 2'h2
	} sfp_state_t;

	// ****************************************
	// Pin drive bundle
	// ****************************************
	typedef struct packed {
		logic [3:0] dout;
		logic [3:0] oe_n;
	} sfp_lane_drv_t;

	localparam int         SFP_BYTE_W     = 8;
	localparam int         SFP_FIFO_DEPTH = 16;
	localparam logic [7:0] SFP_IDLE_FILL  = 8'hFF;
	localparam logic [3:0] SFP_OE_NONE    = 4'hF;
	localparam logic [3:0] SFP_OE_SINGLE  = 4'hD;
	localparam logic [3:0] SFP_OE_DUAL    = 4'hC;
	localparam logic [3:0] SFP_OE_QUAD    = 4'h0;
	localparam logic [3:0] SFP_RST_DOUT   = 4'h0;

endpackage : sfp_pkg

// ==== verilog/sfp_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes writer and reader share clk_i; depth is a power of two.
`timescale 1ns/1ps
module sfp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	// Fill side
	input  wire logic             s_valid_i,
	input  wire logic [WIDTH-1:0] s_data_i,
	output logic                  s_ready_o,
	// Drain side
	output logic                  m_valid_o,
	output logic      [WIDTH-1:0] m_data_o,
	input  wire logic             m_ready_i
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign s_ready_o = (count_reg != (AW+1)'(DEPTH));
	assign m_valid_o = (count_reg != '0);
	assign m_data_o  = mem_reg[rd_ptr_reg];
	assign push      = s_valid_i && s_ready_o;
	assign pop       = m_ready_i && m_valid_o;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= s_data_i;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

endmodule : sfp_fifo

// ==== verilog/sfp_pin_front.sv ====
// Pin-level front end of a serial NOR flash: select, lanes, pause, guard.
// Assumes an instruction decoder beside it supplies lane mode, output phase,
// status lock bits and busy; the serial clock is oversampled by clk_i.
//
// Contract
// RULE1: Chip select high: unselected, inputs ignored, all outputs high impedance.
// RULE2: Deselected and no internal operation running gives standby.
// RULE3: Chip select low enables the device, active power state.
// RULE4: After reset nothing starts before a chip select falling edge.
// RULE5: Instruction, address and data bits captured on serial clock rise.
// RULE6: Output data changes only after a serial clock fall.
// RULE7: Single mode: lane 0 input only, lane 1 output only.
// RULE8: Dual and quad: lanes 0 and 1 bidirectional, in rising, out falling.
// RULE9: Quad: write-guard pin is lane 2, pause pin is lane 3.
// RULE10: Guard low with locks 0 and 1 refuses status writes.
// RULE11: Same lock makes protected regions reject modification.
// RULE12: Four-lane enable disables the write-guard function.
// RULE13: Pause only valid while chip select stays low.
// RULE14: Pause starts on pause fall with clock low, else at clock low.
// RULE15: Pause ends on pause rise with clock low, else at clock low.
// RULE16: Pause leaves internal status-write, program or erase running.
// RULE17: While paused output is high impedance, input and clock ignored.
// RULE18: Chip select rising while paused resets the interface.
// RULE19: Both clock modes 0 and 3 work.
// RULE20: Host holds chip select low through the whole instruction.
`timescale 1ns/1ps
module sfp_pin_front #(
	parameter int TX_DEPTH = sfp_pkg::SFP_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   sys_rst_i,
	// Flash pins
	input  wire logic                   sclk_i,
	input  wire logic                   cs_n_i,
	input  wire logic [3:0]             data_lane_i,
	output sfp_pkg::sfp_lane_drv_t      data_lane_o,
	// Decoder control
	input  sfp_pkg::sfp_lane_mode_t     lane_mode_i,
	input  wire logic                   drive_out_i,
	input  wire logic                   internal_busy_i,
	input  wire logic                   status_lock_upper_i,
	input  wire logic                   status_lock_lower_i,
	input  wire logic                   four_lane_enable_i,
	input  wire logic                   status_write_req_i,
	input  wire logic                   region_protected_i,
	// Outgoing byte stream
	input  wire logic                   tx_valid_i,
	input  wire logic [7:0]             tx_data_i,
	output logic                        tx_ready_o,
	// Incoming byte stream
	output logic                        rx_valid_o,
	output logic [7:0]                  rx_data_o,
	// Status
	output logic                        selected_o,
	output logic                        standby_o,
	output logic                        paused_o,
	output logic                        frame_abort_o,
	output logic                        status_write_ok_o,
	output logic                        status_write_refused_o,
	output logic                        region_write_refused_o
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [5:0] sync1_reg;
	logic [5:0] sync2_reg;
	logic       sclk_d_reg;
	logic       cs_d_reg;
	logic       sclk_s;
	logic       cs_s;
	logic [3:0] lane_s;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			// Select reads low in reset: a pin held low never fakes an arming edge
			sync1_reg  <= 6'h1F;
			sync2_reg  <= 6'h1F;
			sclk_d_reg <= 1'b0;
			cs_d_reg   <= 1'b0;
		end else begin
			sync1_reg  <= {cs_n_i, sclk_i, data_lane_i};
			sync2_reg  <= sync1_reg;
			sclk_d_reg <= sync2_reg[4];
			cs_d_reg   <= sync2_reg[5];
		end
	end

	assign cs_s   = sync2_reg[5];
	assign sclk_s = sync2_reg[4];
	assign lane_s = sync2_reg[3:0];

	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic quad;
	logic hold_low;

	// RULE5 rise detect
	assign sclk_rise = sclk_s && !sclk_d_reg;
	// RULE6 fall detect
	assign sclk_fall = !sclk_s && sclk_d_reg;
	assign cs_fall   = !cs_s && cs_d_reg;
	assign quad      = (lane_mode_i == sfp_pkg::SFP_LANES_QUAD);
	// RULE9 pause pin is data in quad
	assign hold_low  = !lane_s[3] && !quad;

	// ****************************************
	// Select and pause state
	// ****************************************
	sfp_pkg::sfp_state_t state_reg;
	logic                active;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= sfp_pkg::SFP_ST_UNARMED;
		end else begin
			case (state_reg)
				// RULE4 wait for a select edge
				sfp_pkg::SFP_ST_UNARMED: begin
					if (cs_fall) begin
						state_reg <= sfp_pkg::SFP_ST_SELECTED;
					end
				end
				// RULE3 select on low
				sfp_pkg::SFP_ST_IDLE: begin
					if (!cs_s) begin
						state_reg <= sfp_pkg::SFP_ST_SELECTED;
					end
				end
				// RULE13 pause only from selected
				sfp_pkg::SFP_ST_SELECTED: begin
					if (cs_s) begin
						state_reg <= sfp_pkg::SFP_ST_IDLE;
					// RULE14 enter pause at clock low
					end else if (hold_low && !sclk_s) begin
						state_reg <= sfp_pkg::SFP_ST_PAUSED;
					end
				end
				sfp_pkg::SFP_ST_PAUSED: begin
					// RULE18 deselect resets interface
					if (cs_s) begin
						state_reg <= sfp_pkg::SFP_ST_IDLE;
					// RULE15 leave pause at clock low
					end else if (!hold_low && !sclk_s) begin
						state_reg <= sfp_pkg::SFP_ST_SELECTED;
					end
				end
				default: begin
					state_reg <= sfp_pkg::SFP_ST_UNARMED;
				end
			endcase
		end
	end

	// RULE17 paused ignores clock and input
	assign active = (state_reg == sfp_pkg::SFP_ST_SELECTED);

	// ****************************************
	// Receive shifter
	// ****************************************
	logic [7:0] rx_sh_reg;
	logic [2:0] rx_cnt_reg;
	logic       seen_rise_reg;
	logic [7:0] rx_sh_next;
	logic [2:0] rx_cnt_next;
	logic       rx_take;

	// RULE8 lanes inward only outside the output phase
	assign rx_take = active && sclk_rise && !drive_out_i;

	always_comb begin
		rx_sh_next  = rx_sh_reg;
		rx_cnt_next = rx_cnt_reg;
		case (lane_mode_i)
			// RULE7 single takes lane 0 only
			sfp_pkg::SFP_LANES_SINGLE: begin
				rx_sh_next  = {rx_sh_reg[6:0], lane_s[0]};
				rx_cnt_next = rx_cnt_reg + 3'h1;
			end
			sfp_pkg::SFP_LANES_DUAL: begin
				rx_sh_next  = {rx_sh_reg[5:0], lane_s[1:0]};
				rx_cnt_next = rx_cnt_reg + 3'h2;
			end
			sfp_pkg::SFP_LANES_QUAD: begin
				rx_sh_next  = {rx_sh_reg[3:0], lane_s};
				rx_cnt_next = rx_cnt_reg + 3'h4;
			end
			default: begin
				rx_sh_next  = rx_sh_reg;
				rx_cnt_next = rx_cnt_reg;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_sh_reg     <= 8'h00;
			rx_cnt_reg    <= 3'h0;
			seen_rise_reg <= 1'b0;
			rx_valid_o    <= 1'b0;
			rx_data_o     <= 8'h00;
		end else begin
			rx_valid_o <= 1'b0;
			// RULE1 deselect drops partial bits
			if (state_reg != sfp_pkg::SFP_ST_SELECTED &&
			    state_reg != sfp_pkg::SFP_ST_PAUSED) begin
				rx_sh_reg     <= 8'h00;
				rx_cnt_reg    <= 3'h0;
				seen_rise_reg <= 1'b0;
			end else if (rx_take) begin
				// RULE5 capture on rise
				rx_sh_reg     <= rx_sh_next;
				rx_cnt_reg    <= rx_cnt_next;
				seen_rise_reg <= 1'b1;
				if (rx_cnt_next == 3'h0) begin
					rx_valid_o <= 1'b1;
					rx_data_o  <= rx_sh_next;
				end
			end else if (active && sclk_rise) begin
				seen_rise_reg <= 1'b1;
			end
		end
	end

	// ****************************************
	// Transmit path
	// ****************************************
	logic       fifo_valid;
	logic [7:0] fifo_data;
	logic       fifo_pop;
	logic       fifo_ready;
	logic [7:0] tx_sh_reg;
	logic [3:0] tx_left_reg;
	logic       tx_step;
	logic       tx_load;
	logic [7:0] tx_word;
	logic [3:0] tx_bits;

	sfp_fifo #(
		.WIDTH (sfp_pkg::SFP_BYTE_W),
		.DEPTH (TX_DEPTH)
	) u_tx_fifo (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.s_valid_i (tx_valid_i),
		.s_data_i  (tx_data_i),
		.s_ready_o (fifo_ready),
		.m_valid_o (fifo_valid),
		.m_data_o  (fifo_data),
		.m_ready_i (fifo_pop)
	);

	// RULE19 mode 3 idles high, so a fall before any rise is skipped
	assign tx_step  = active && sclk_fall && seen_rise_reg && drive_out_i;
	assign tx_load  = tx_step && (tx_left_reg == 4'h0);
	assign fifo_pop = tx_load && fifo_valid;
	// Underrun sends filler rather than stalling the host clock
	assign tx_word  = tx_load ? (fifo_valid ? fifo_data : sfp_pkg::SFP_IDLE_FILL)
	                          : tx_sh_reg;

	always_comb begin
		case (lane_mode_i)
			sfp_pkg::SFP_LANES_DUAL: tx_bits = 4'h2;
			sfp_pkg::SFP_LANES_QUAD: tx_bits = 4'h4;
			default:                 tx_bits = 4'h1;
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tx_sh_reg        <= 8'h00;
			tx_left_reg      <= 4'h0;
			data_lane_o.dout <= sfp_pkg::SFP_RST_DOUT;
		end else if (state_reg != sfp_pkg::SFP_ST_SELECTED &&
		             state_reg != sfp_pkg::SFP_ST_PAUSED) begin
			tx_left_reg <= 4'h0;
		end else if (tx_step) begin
			// RULE6 drive after fall
			tx_sh_reg   <= tx_word << tx_bits;
			tx_left_reg <= (tx_load ? 4'h8 : tx_left_reg) - tx_bits;
			case (lane_mode_i)
				sfp_pkg::SFP_LANES_DUAL: data_lane_o.dout <= {2'h0, tx_word[7:6]};
				sfp_pkg::SFP_LANES_QUAD: data_lane_o.dout <= tx_word[7:4];
				default:                 data_lane_o.dout <= {2'h0, tx_word[7], 1'b0};
			endcase
		end
	end

	// RULE1 outputs released unless selected and driving
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			data_lane_o.oe_n <= sfp_pkg::SFP_OE_NONE;
		end else if (!active || !drive_out_i) begin
			data_lane_o.oe_n <= sfp_pkg::SFP_OE_NONE;
		end else begin
			case (lane_mode_i)
				// RULE7 lane 1 is the only output
				sfp_pkg::SFP_LANES_SINGLE: data_lane_o.oe_n <= sfp_pkg::SFP_OE_SINGLE;
				// RULE8 lanes 0 and 1 outward
				sfp_pkg::SFP_LANES_DUAL:   data_lane_o.oe_n <= sfp_pkg::SFP_OE_DUAL;
				// RULE9 all four lanes outward
				sfp_pkg::SFP_LANES_QUAD:   data_lane_o.oe_n <= sfp_pkg::SFP_OE_QUAD;
				default:                   data_lane_o.oe_n <= sfp_pkg::SFP_OE_NONE;
			endcase
		end
	end

	// ****************************************
	// Status, power and write guard
	// ****************************************
	logic guard_lock;

	// RULE12 four-lane enable removes the guard
	assign guard_lock = !four_lane_enable_i && !lane_s[2] &&
	                    !status_lock_upper_i && status_lock_lower_i;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			selected_o             <= 1'b0;
			standby_o              <= 1'b1;
			paused_o               <= 1'b0;
			frame_abort_o          <= 1'b0;
			status_write_ok_o      <= 1'b0;
			status_write_refused_o <= 1'b0;
			region_write_refused_o <= 1'b0;
			tx_ready_o             <= 1'b0;
		end else begin
			// RULE3 active while selected
			selected_o    <= active || (state_reg == sfp_pkg::SFP_ST_PAUSED);
			// RULE2 standby only when unarmed or idle and not busy
			// RULE16 busy is never touched by pause
			standby_o     <= !active && (state_reg != sfp_pkg::SFP_ST_PAUSED) &&
			                 !internal_busy_i;
			paused_o      <= (state_reg == sfp_pkg::SFP_ST_PAUSED);
			// RULE18 abort on deselect mid frame
			frame_abort_o <= cs_s && (state_reg == sfp_pkg::SFP_ST_PAUSED ||
			                          (active && rx_cnt_reg != 3'h0));
			// RULE10 refuse status writes
			status_write_refused_o <= guard_lock;
			status_write_ok_o      <= status_write_req_i && !guard_lock;
			// RULE11 protected regions locked
			region_write_refused_o <= guard_lock && region_protected_i;
			tx_ready_o             <= fifo_ready;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	chk_desel_hiz: assert property ( // RULE1
		(state_reg != sfp_pkg::SFP_ST_SELECTED) |=> data_lane_o.oe_n == 4'hF)
		else $error("lanes driven while not selected");
	chk_idle_standby: assert property ( // RULE2
		(state_reg == sfp_pkg::SFP_ST_IDLE && !internal_busy_i) |=> standby_o)
		else $error("no standby while idle");
	chk_sel_active: assert property ( // RULE3
		(state_reg == sfp_pkg::SFP_ST_SELECTED) |=> selected_o && !standby_o)
		else $error("selected but not active");
	chk_need_edge: assert property ( // RULE4
		(state_reg == sfp_pkg::SFP_ST_UNARMED && !cs_fall) |=>
		state_reg == sfp_pkg::SFP_ST_UNARMED)
		else $error("left unarmed without select edge");
	chk_rx_at_rise: assert property ( // RULE5
		rx_valid_o |-> $past(sclk_rise) && $past(active))
		else $error("byte completed without rising edge");
	chk_dout_on_fall: assert property ( // RULE6
		!(sclk_fall && active) |=> $stable(data_lane_o.dout))
		else $error("output changed without falling edge");
	chk_single_lanes: assert property ( // RULE7
		(lane_mode_i == sfp_pkg::SFP_LANES_SINGLE) |=> data_lane_o.oe_n[0])
		else $error("lane 0 driven in single mode");
	chk_guard_refuse: assert property ( // RULE10
		guard_lock |=> status_write_refused_o && !status_write_ok_o)
		else $error("status write not refused");
	chk_quad_guard_off: assert property ( // RULE12
		four_lane_enable_i |=> !status_write_refused_o)
		else $error("guard active with four lanes");
	chk_pause_entry: assert property ( // RULE14
		(active && !cs_s && hold_low && !sclk_s) |=>
		state_reg == sfp_pkg::SFP_ST_PAUSED)
		else $error("pause not entered at clock low");
	chk_pause_hiz: assert property ( // RULE17
		(state_reg == sfp_pkg::SFP_ST_PAUSED) |=> data_lane_o.oe_n == 4'hF)
		else $error("lanes driven while paused");
	chk_pause_abort: assert property ( // RULE18
		(state_reg == sfp_pkg::SFP_ST_PAUSED && cs_s) |=>
		state_reg == sfp_pkg::SFP_ST_IDLE && frame_abort_o)
		else $error("deselect in pause did not reset");

endmodule : sfp_pin_front

// ==== bench/sfp_host_model.sv ====
// Host controller model: drives serial clock, select and the four lanes.
// Assumes the bench resolves lane levels and feeds them back on lane_i.
`timescale 1ns/1ps
module sfp_host_model (
	// Pacing clock
	input  wire logic       clk_i,
	// Resolved lane levels
	input  wire logic [3:0] lane_i,
	// Host pins
	output logic            sclk_o,
	output logic            cs_n_o,
	output logic [3:0]      lane_o,
	output logic [3:0]      lane_oe_n_o
);
	// 16 cycles of 5 ns per phase, plus one per bit, give a 165 ns serial period; raise it to stall
	int half_cyc = 16;

	// Starts selected so a missing arming edge can be shown
	initial begin
		sclk_o = 1'b1;
		cs_n_o = 1'b0;
		lane_o = 4'hC;
		lane_oe_n_o = 4'h2;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wait_clk

	// select moved high or low from a settled clock
	// select held until the caller ends the frame
	task automatic set_cs(input logic v, input logic idle);
		@(posedge clk_i);
		sclk_o <= idle;
		wait_clk(half_cyc);
		cs_n_o <= v;
		wait_clk(half_cyc);
	endtask : set_cs

	// one host lane moved, guard or pause pin, with select high or low
	task automatic set_pin(input int idx, input logic v);
		@(posedge clk_i);
		lane_o[idx] <= v;
	endtask : set_pin

	task automatic set_sclk(input logic v);
		@(posedge clk_i);
		sclk_o <= v;
	endtask : set_sclk

	// lanes released to the device in its output phase
	task automatic bit_cyc(input int w, input logic [3:0] d, input logic rd,
			output logic [3:0] q);
		@(posedge clk_i);
		sclk_o <= 1'b0;
		if (w == 4) lane_o <= d;
		else lane_o[1:0] <= d[1:0];
		if (rd) lane_oe_n_o <= (w == 1) ? 4'h2 : (w == 2) ? 4'h3 : 4'hF;
		else lane_oe_n_o <= (w == 1) ? 4'h2 : 4'h0;
		wait_clk(half_cyc);
		sclk_o <= 1'b1;
		q = lane_i;
		wait_clk(half_cyc);
	endtask : bit_cyc

	task automatic shift_byte(input int w, input logic [7:0] tx, input logic rd,
			output logic [7:0] rx);
		logic [3:0] q;
		logic [7:0] sr;
		sr = tx;
		rx = 8'h00;
		for (int i = 0; i < 8 / w; i++) begin
			bit_cyc(w, (w == 1) ? {3'h0, sr[7]} : (w == 2) ? {2'h0, sr[7:6]} : sr[7:4], rd, q);
			sr = sr << w;
			rx = (w == 1) ? {rx[6:0], q[1]} : (w == 2) ? {rx[5:0], q[1:0]} : {rx[3:0], q};
		end
	endtask : shift_byte

endmodule : sfp_host_model

// ==== bench/testbench.sv ====
// Self-checking bench for the flash pin front end with a host model.
// Assumes the package constants; guard and pause lanes pulled up.
`timescale 1ns/1ps
module testbench;
	logic                    clk_i = 1'b0;
	logic                    sys_rst_i = 1'b1;
	sfp_pkg::sfp_lane_mode_t lane_mode_i = sfp_pkg::SFP_LANES_SINGLE;
	logic                    drive_out_i = 1'b0;
	logic                    internal_busy_i = 1'b0;
	logic                    status_lock_upper_i = 1'b0;
	logic                    status_lock_lower_i = 1'b0;
	logic                    four_lane_enable_i = 1'b0;
	logic                    status_write_req_i = 1'b0;
	logic                    region_protected_i = 1'b0;
	logic                    tx_valid_i = 1'b0;
	logic [7:0]              tx_data_i = 8'h00;
	sfp_pkg::sfp_lane_drv_t  data_lane_o;
	logic                    tx_ready_o;
	logic                    rx_valid_o;
	logic [7:0]              rx_data_o;
	logic                    selected_o;
	logic                    standby_o;
	logic                    paused_o;
	logic                    frame_abort_o;
	logic                    status_write_ok_o;
	logic                    status_write_refused_o;
	logic                    region_write_refused_o;
	logic                    sclk;
	logic                    cs_n;
	logic [3:0]              host_d;
	logic [3:0]              host_oe_n;
	logic [3:0]              lane_w;
	logic                    float_q = 1'b0;
	logic [7:0]              rx_q[$];
	logic [7:0]              exp_q[$];
	int                      abort_cnt = 0;
	int                      failures = 0;
	int                      samples_checked = 0;
	sfp_pkg::sfp_lane_mode_t modes [3] = '{sfp_pkg::SFP_LANES_SINGLE,
		sfp_pkg::SFP_LANES_DUAL, sfp_pkg::SFP_LANES_QUAD};
	logic [3:0]              oe_exp [3] = '{sfp_pkg::SFP_OE_SINGLE,
		sfp_pkg::SFP_OE_DUAL, sfp_pkg::SFP_OE_QUAD};

	always #2.5 clk_i = ~clk_i;

	// Released lanes 0 and 1 wander so a stale level never passes
	always @(posedge clk_i) float_q <= ~float_q;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (!data_lane_o.oe_n[i]) lane_w[i] = data_lane_o.dout[i];
			else if (!host_oe_n[i]) lane_w[i] = host_d[i];
			else lane_w[i] = (i >= 2) ? 1'b1 : float_q;
		end
	end

	always @(posedge clk_i) begin
		if (rx_valid_o === 1'b1) rx_q.push_back(rx_data_o);
		if (frame_abort_o === 1'b1) abort_cnt++;
	end

	sfp_pin_front i_sfp_pin_front (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
		.data_lane_i(lane_w), .data_lane_o(data_lane_o), .lane_mode_i(lane_mode_i),
		.drive_out_i(drive_out_i), .internal_busy_i(internal_busy_i),
		.status_lock_upper_i(status_lock_upper_i), .status_lock_lower_i(status_lock_lower_i),
		.four_lane_enable_i(four_lane_enable_i), .status_write_req_i(status_write_req_i),
		.region_protected_i(region_protected_i), .tx_valid_i(tx_valid_i),
		.tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o),
		.rx_data_o(rx_data_o), .selected_o(selected_o), .standby_o(standby_o),
		.paused_o(paused_o), .frame_abort_o(frame_abort_o),
		.status_write_ok_o(status_write_ok_o), .status_write_refused_o(status_write_refused_o),
		.region_write_refused_o(region_write_refused_o));

	sfp_host_model i_sfp_host_model (.clk_i(clk_i), .lane_i(lane_w), .sclk_o(sclk),
		.cs_n_o(cs_n), .lane_o(host_d), .lane_oe_n_o(host_oe_n));

	// ****************************************
	// Checking helpers
	// ****************************************
	task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_val

	task automatic cmp_flag(input logic got, input logic exp);
		cmp_val({7'h00, got}, {7'h00, exp});
	endtask : cmp_flag

	task automatic chk_rx(input logic [7:0] exp);
		logic [7:0] got;
		got = 8'hXX;
		if (rx_q.size() != 0) got = rx_q.pop_front();
		cmp_val(got, exp);
	endtask : chk_rx

	function automatic logic guard_lock(input logic [3:0] g);
		return !g[3] && !g[2] && g[1] && !g[0];
	endfunction : guard_lock

	// Pushes spaced three cycles apart since ready lags the fill level
	task automatic fill(input int max_n, output int n);
		logic push;
		logic [7:0] b;
		n = 0;
		for (int k = 0; k < 3 * max_n + 6; k++) begin
			@(posedge clk_i);
			push = (k % 3 == 0) && (n < max_n) && (tx_ready_o === 1'b1);
			b = 8'($urandom);
			tx_valid_i <= push;
			tx_data_i <= b;
			if (push) exp_q.push_back(b);
			if (push) n++;
		end
	endtask : fill

	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (60000) @(posedge clk_i);
		failures++;
		final_report();
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		logic [7:0] b;
		logic [7:0] r;
		logic [3:0] q;
		logic [3:0] g;
		int n;
		int w;
		void'($urandom(64));
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		cmp_val({4'h0, data_lane_o.oe_n}, {4'h0, sfp_pkg::SFP_OE_NONE});
		i_sfp_host_model.shift_byte(1, 8'hA5, 1'b0, r);
		cmp_flag(selected_o, 1'b0);
		cmp_val(8'(rx_q.size()), 8'h00);
		i_sfp_host_model.set_cs(1'b1, 1'b1);
		i_sfp_host_model.shift_byte(1, 8'h3C, 1'b0, r);
		cmp_val(8'(rx_q.size()), 8'h00);
		cmp_flag(standby_o, 1'b1);
		internal_busy_i <= 1'b1;
		i_sfp_host_model.set_cs(1'b0, 1'b1);
		cmp_flag(selected_o, 1'b1);
		cmp_flag(standby_o, 1'b0);
		i_sfp_host_model.set_cs(1'b1, 1'b1);
		cmp_flag(standby_o, 1'b0);
		internal_busy_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		cmp_flag(standby_o, 1'b1);
		// Each lane width in both clock idle levels, extremes first
		for (int k = 0; k < 6; k++) begin
			w = 1 << (k / 2);
			lane_mode_i <= modes[k / 2];
			i_sfp_host_model.set_cs(1'b0, k[0]);
			for (int j = 0; j < 3; j++) begin
				b = (j == 0) ? 8'h00 : (j == 1) ? 8'hFF : 8'($urandom);
				i_sfp_host_model.shift_byte(w, b, 1'b0, r);
				chk_rx(b);
			end
			cmp_flag(paused_o, 1'b0);
			i_sfp_host_model.set_cs(1'b1, k[0]);
		end
		i_sfp_host_model.set_pin(2, 1'b1);
		i_sfp_host_model.set_pin(3, 1'b1);
		// Reads: full buffer once, then short bursts, each ending in underrun
		drive_out_i <= 1'b1;
		for (int m = 0; m < 3; m++) begin
			w = 1 << m;
			lane_mode_i <= modes[m];
			fill((m == 0) ? 20 : 2, n);
			cmp_val(8'(n), (m == 0) ? 8'(sfp_pkg::SFP_FIFO_DEPTH) : 8'h02);
			cmp_flag(tx_ready_o, (m != 0));
			i_sfp_host_model.set_cs(1'b0, 1'b1);
			// Last dummy clock of a read: output starts at the next fall
			i_sfp_host_model.bit_cyc(w, 4'hF, 1'b1, q);
			for (int j = 0; j <= n; j++) begin
				i_sfp_host_model.shift_byte(w, 8'hFF, 1'b1, r);
				cmp_val(r, (j < n) ? exp_q.pop_front() : sfp_pkg::SFP_IDLE_FILL);
				cmp_val({4'h0, data_lane_o.oe_n}, {4'h0, oe_exp[m]});
			end
			i_sfp_host_model.set_cs(1'b1, 1'b1);
		end
		drive_out_i <= 1'b0;
		lane_mode_i <= sfp_pkg::SFP_LANES_SINGLE;
		// Pause entered and left with the clock high, then low
		b = 8'($urandom);
		i_sfp_host_model.set_cs(1'b0, 1'b0);
		for (int i = 0; i < 4; i++) i_sfp_host_model.bit_cyc(1, {3'h0, b[7 - i]}, 1'b0, q);
		i_sfp_host_model.set_pin(3, 1'b0);
		repeat (8) @(posedge clk_i);
		cmp_flag(paused_o, 1'b0);
		i_sfp_host_model.set_sclk(1'b0);
		repeat (8) @(posedge clk_i);
		cmp_flag(paused_o, 1'b1);
		cmp_val({4'h0, data_lane_o.oe_n}, {4'h0, sfp_pkg::SFP_OE_NONE});
		for (int i = 0; i < 2; i++) i_sfp_host_model.bit_cyc(1, {3'h0, ~b[3]}, 1'b0, q);
		i_sfp_host_model.set_pin(3, 1'b1);
		repeat (8) @(posedge clk_i);
		cmp_flag(paused_o, 1'b1);
		i_sfp_host_model.set_sclk(1'b0);
		repeat (8) @(posedge clk_i);
		cmp_flag(paused_o, 1'b0);
		for (int i = 4; i < 8; i++) i_sfp_host_model.bit_cyc(1, {3'h0, b[7 - i]}, 1'b0, q);
		chk_rx(b);
		// Deselect in mid-byte while paused
		for (int i = 0; i < 3; i++) i_sfp_host_model.bit_cyc(1, {3'h0, b[i]}, 1'b0, q);
		i_sfp_host_model.set_sclk(1'b0);
		i_sfp_host_model.set_pin(3, 1'b0);
		repeat (8) @(posedge clk_i);
		cmp_flag(paused_o, 1'b1);
		n = abort_cnt;
		i_sfp_host_model.set_cs(1'b1, 1'b0);
		cmp_val(8'(abort_cnt - n), 8'h01);
		cmp_flag(paused_o, 1'b0);
		i_sfp_host_model.set_pin(3, 1'b1);
		i_sfp_host_model.set_cs(1'b0, 1'b0);
		b = 8'($urandom);
		i_sfp_host_model.shift_byte(1, b, 1'b0, r);
		chk_rx(b);
		// Guard lock: forced lock, lifted by four-lane enable, then random
		status_write_req_i <= 1'b1;
		region_protected_i <= 1'b1;
		for (int k = 0; k < 12; k++) begin
			g = (k == 0) ? 4'h2 : (k == 1) ? 4'hA : 4'($urandom);
			four_lane_enable_i <= g[3];
			status_lock_upper_i <= g[2];
			status_lock_lower_i <= g[1];
			i_sfp_host_model.set_pin(2, g[0]);
			repeat (8) @(posedge clk_i);
			cmp_flag(status_write_refused_o, guard_lock(g));
			cmp_flag(status_write_ok_o, !guard_lock(g));
			cmp_flag(region_write_refused_o, guard_lock(g));
		end
		i_sfp_host_model.set_pin(2, 1'b1);
		i_sfp_host_model.set_cs(1'b1, 1'b0);
		final_report();
	end

endmodule : testbench
